// ===== fiber_fault_defines.svh
// Functional notes
// - fiber select pin low at reset selects fiber
// - fiber enable bit acts like pin low
// - fiber mode enables interface, fault, bypass; here fault signalling also needs auto-negotiation off
// - fiber interface disables twisted-pair transceiver
// - transmit NRZI with scrambler bypassed
// - receive NRZI with descrambler bypassed
// - signal detect means adequate signal present
// - lost signal sends 84 ones, one zero
// - fault idle until signal detect returns
// - three patterns latch remote fault until read
// - fault also shown in phy status bit
// - first pattern may hold extra ones
// - fault idle never asserts carrier sense
// - fault signalling disabled sends no pattern
// - far-end fault blocks MII data activity
// - auto-negotiation enabled disables fault signalling
// - fiber configuration enables fault signalling; here it also needs auto-negotiation off, which resets on even with the pin low
// - scrambler bypass at bit 11 of register 17h
// - pcs bit 15 biases negative signal detect
`ifndef FIBER_FAULT_DEFINES_SVH
`define FIBER_FAULT_DEFINES_SVH
`define ADDR_BASIC_CONTROL  5'h00
`define ADDR_BASIC_STATUS   5'h01
`define ADDR_PHY_STATUS     5'h10
`define ADDR_PCS_CONFIG     5'h16
`define ADDR_LOOPBACK_BYP   5'h17
`define ADDR_PHY_CONTROL    5'h19
`define BIT_AUTONEG_EN      12
`define BIT_REMOTE_FAULT    4
`define BIT_PHY_STATUS_REG_FAULT    7
`define BIT_FAULT_SIG_EN    14
`define BIT_SD_BIAS         15
`define BIT_BYPASS_SCR      11
`define BIT_FIBER_EN        5
`define MODE_MSB            9
`define MODE_LSB            7
`define MODE_FIBER          3'h3
`define RST_BASIC_CONTROL   16'h1000
`define FAULT_ONES          7'h54
`define FAULT_DETECT_COUNT  2'h3
`endif

// ===== fiber_fault_pkg.sv
package fiber_fault_pkg;
	typedef logic [4:0]  reg_addr_t;
	typedef logic [15:0] reg_data_t;
	typedef enum logic {TX_NORMAL, TX_FAULT} tx_mode_e;
endpackage

// ===== fiber_mode_far_end_fault.sv
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "fiber_fault_defines.svh"
module fiber_mode_far_end_fault
(
	input  wire logic                      i_core_clk,
	input  wire logic                      i_rst_b,
	input  wire logic                      i_fiber_select_pin_b,
	input  wire fiber_fault_pkg::reg_addr_t i_addr,
	input  wire fiber_fault_pkg::reg_data_t i_wdata,
	input  wire logic                      i_wr,
	input  wire logic                      i_rd,
	output fiber_fault_pkg::reg_data_t      o_rdata,
	input  wire logic                      i_fiber_signal_detect,
	input  wire logic                      i_tx_code_bit,
	input  wire logic                      i_tx_idle,
	output logic                           o_fiber_tx_bit,
	input  wire logic                      i_fiber_rx_bit,
	output logic                           o_rx_code_bit,
	input  wire logic                      i_rx_carrier,
	output logic                           o_mii_crs,
	output logic                           o_mii_enable,
	output logic                           o_fiber_if_en,
	output logic                           o_tp_xcvr_en,
	output logic                           o_scrambler_bypass,
	output logic                           o_sd_bias_en
);
	import fiber_fault_pkg::*;

	logic       fiber_mode_reg;
	logic       autoneg_reg;
	logic       fault_en_reg;
	logic       sd_bias_reg;
	logic       bypass_reg;
	logic [2:0] lb_mode_reg;
	logic       fiber_bit_reg;
	logic       remote_fault_reg;
	logic       fault_live_reg;
	logic [6:0] tx_cnt_reg;
	logic       tx_nrzi_reg;
	logic       rx_prev_reg;
	logic [6:0] rx_ones_reg;
	logic [1:0] rx_pat_reg;
	tx_mode_e   tx_mode_reg;
	logic       fiber_eff;
	logic       fault_sig_eff;
	logic       tx_bit;
	logic       rx_bit;
	logic       pattern_hit;
	logic       status_read;

	function automatic logic hit(input reg_addr_t a, input reg_addr_t r);
		return a == r;
	endfunction

	// fiber when pin strap, software bit or loopback mode field value 3 selects it
	assign fiber_eff = fiber_mode_reg | fiber_bit_reg | (lb_mode_reg == `MODE_FIBER);
	assign fault_sig_eff = fault_en_reg & fiber_eff & ~autoneg_reg;
	assign status_read = i_rd & hit(i_addr, `ADDR_BASIC_STATUS);

	// strap sampled during reset
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_b)
			fiber_mode_reg <= ~i_fiber_select_pin_b;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_b)
		begin
			autoneg_reg   <= 1'b1;
			fault_en_reg  <= 1'b1;
			sd_bias_reg   <= 1'b0;
			bypass_reg    <= 1'b0;
			lb_mode_reg   <= 3'h0;
			fiber_bit_reg <= 1'b0;
		end
		else if (i_wr)
		begin
			if (hit(i_addr, `ADDR_BASIC_CONTROL))
				autoneg_reg <= i_wdata[`BIT_AUTONEG_EN];
			if (hit(i_addr, `ADDR_PCS_CONFIG))
			begin
				fault_en_reg <= i_wdata[`BIT_FAULT_SIG_EN];
				sd_bias_reg  <= i_wdata[`BIT_SD_BIAS];
			end
			if (hit(i_addr, `ADDR_LOOPBACK_BYP))
			begin
				bypass_reg  <= i_wdata[`BIT_BYPASS_SCR];
				lb_mode_reg <= i_wdata[`MODE_MSB:`MODE_LSB];
			end
			if (hit(i_addr, `ADDR_PHY_CONTROL))
				fiber_bit_reg <= i_wdata[`BIT_FIBER_EN];
		end
	end

	// transmit: fault idle generator and NRZI
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_b)
		begin
			tx_mode_reg <= TX_NORMAL;
			tx_cnt_reg  <= 7'd0;
		end
		else
		begin
			case (tx_mode_reg)
				TX_NORMAL:
				begin
					tx_cnt_reg <= 7'd0;
					if (fault_sig_eff && !i_fiber_signal_detect && i_tx_idle)
						tx_mode_reg <= TX_FAULT;
				end
				TX_FAULT:
				begin
					tx_cnt_reg <= (tx_cnt_reg == `FAULT_ONES) ? 7'd0 : tx_cnt_reg + 7'd1;
					if (i_fiber_signal_detect || !fault_sig_eff)
						tx_mode_reg <= TX_NORMAL;
				end
				default:
					tx_mode_reg <= TX_NORMAL;
			endcase
		end
	end

	assign tx_bit = (tx_mode_reg == TX_FAULT) ? (tx_cnt_reg != `FAULT_ONES) : i_tx_code_bit;

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_b)
			tx_nrzi_reg <= 1'b0;
		else if (fiber_eff)
			tx_nrzi_reg <= tx_nrzi_reg ^ tx_bit;
		else
			tx_nrzi_reg <= tx_bit;
	end
	assign o_fiber_tx_bit = tx_nrzi_reg;

	// receive: NRZI decode and pattern detector
	assign rx_bit = fiber_eff ? (i_fiber_rx_bit ^ rx_prev_reg) : i_fiber_rx_bit;
	// long first run of ones is fine: only zero placement is checked
	assign pattern_hit = !rx_bit && (rx_ones_reg >= `FAULT_ONES);

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_b)
		begin
			rx_prev_reg <= 1'b0;
			rx_ones_reg <= 7'd0;
			rx_pat_reg  <= 2'd0;
			o_rx_code_bit <= 1'b1;
		end
		else
		begin
			rx_prev_reg   <= i_fiber_rx_bit;
			o_rx_code_bit <= rx_bit;
			if (rx_bit)
				rx_ones_reg <= (rx_ones_reg == 7'h7F) ? rx_ones_reg : rx_ones_reg + 7'd1;
			else
				rx_ones_reg <= 7'd0;
			if (pattern_hit)
				rx_pat_reg <= (rx_pat_reg == `FAULT_DETECT_COUNT) ? rx_pat_reg : rx_pat_reg + 2'd1;
			else if (!rx_bit || rx_ones_reg > `FAULT_ONES && rx_pat_reg != 2'd0 && rx_ones_reg == 7'h7F)
				rx_pat_reg <= 2'd0;
		end
	end

	// live fault and latched remote fault; set wins over read clear
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_b)
		begin
			fault_live_reg   <= 1'b0;
			remote_fault_reg <= 1'b0;
		end
		else
		begin
			fault_live_reg <= fault_sig_eff && (rx_pat_reg == `FAULT_DETECT_COUNT);
			if (fault_sig_eff && rx_pat_reg == `FAULT_DETECT_COUNT)
				remote_fault_reg <= 1'b1;
			else if (status_read)
				remote_fault_reg <= 1'b0;
		end
	end

	// gated MII and line side enables
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_b)
		begin
			o_mii_crs          <= 1'b0;
			o_mii_enable       <= 1'b1;
			o_fiber_if_en      <= 1'b0;
			o_tp_xcvr_en       <= 1'b1;
			o_scrambler_bypass <= 1'b0;
			o_sd_bias_en       <= 1'b0;
		end
		else
		begin
			o_mii_crs          <= i_rx_carrier && !fault_live_reg && rx_pat_reg == 2'd0;
			o_mii_enable       <= !fault_live_reg;
			o_fiber_if_en      <= fiber_eff;
			o_tp_xcvr_en       <= !fiber_eff;
			o_scrambler_bypass <= fiber_eff | bypass_reg;
			o_sd_bias_en       <= sd_bias_reg;
		end
	end

	// read data one cycle after strobe
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_b)
			o_rdata <= 16'h0000;
		else if (!i_rd)
			o_rdata <= 16'h0000;
		else
		begin
			case (i_addr)
				`ADDR_BASIC_CONTROL: o_rdata <= 16'(autoneg_reg) << `BIT_AUTONEG_EN;
				`ADDR_BASIC_STATUS:  o_rdata <= 16'(remote_fault_reg) << `BIT_REMOTE_FAULT;
				`ADDR_PHY_STATUS:    o_rdata <= 16'(fault_live_reg) << `BIT_PHY_STATUS_REG_FAULT;
				`ADDR_PCS_CONFIG:    o_rdata <= (16'(fault_en_reg) << `BIT_FAULT_SIG_EN)
					| (16'(sd_bias_reg) << `BIT_SD_BIAS);
				`ADDR_LOOPBACK_BYP:  o_rdata <= (16'(bypass_reg) << `BIT_BYPASS_SCR)
					| (16'(lb_mode_reg) << `MODE_LSB);
				`ADDR_PHY_CONTROL:   o_rdata <= 16'(fiber_bit_reg | fiber_mode_reg) << `BIT_FIBER_EN;
				default:             o_rdata <= 16'h0000;
			endcase
		end
	end
endmodule

// ===== fiber_fault_asserts.sv
`timescale 1ns/1ns
module fiber_fault_asserts
(
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_tx_code_bit,
	input wire logic i_tx_idle,
	input wire logic i_fiber_signal_detect,
	input wire logic i_fiber_rx_bit,
	input wire logic i_rx_carrier,
	input wire logic o_fiber_tx_bit,
	input wire logic o_rx_code_bit,
	input wire logic o_mii_crs,
	input wire logic o_mii_enable,
	input wire logic o_fiber_if_en,
	input wire logic o_tp_xcvr_en,
	input wire logic o_scrambler_bypass
);
	localparam int ONES = 84;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	logic       tp;
	logic       rp;
	logic [7:0] ones;
	logic [7:0] rones;
	logic [1:0] pats;
	// nrzi zero seen on each line
	wire txz = o_fiber_tx_bit == tp;
	wire rxz = i_fiber_rx_bit == rp;
	always_ff @(posedge i_core_clk) tp <= o_fiber_tx_bit;
	always_ff @(posedge i_core_clk) rp <= i_fiber_rx_bit;
	always_ff @(posedge i_core_clk) ones <= (!i_rst_b || txz) ? 8'h0 : ones + {7'h0, ones != 8'hFF};
	always_ff @(posedge i_core_clk) rones <= (!i_rst_b || rxz) ? 8'h0 : rones + {7'h0, rones != 8'hFF};
	always_ff @(posedge i_core_clk) pats <= !i_rst_b ? 2'h0 : !rxz ? pats : rones < ONES ? 2'h0 : pats + {1'h0, pats != 2'h3};
	sequence s_fault_zero;
		(i_tx_idle && o_fiber_if_en)[*4] ##0 txz;
	endsequence
	chk_fault_run: assert property (s_fault_zero |-> ones >= ONES)
		else $error("short fault run");
	chk_fault_stop: assert property ((i_fiber_signal_detect && i_tx_idle && o_fiber_if_en)[*8] |-> !txz)
		else $error("fault idle with signal");
	chk_tx_nrzi: assert property (o_fiber_if_en && $past(o_fiber_if_en) && !$past(i_tx_idle)
		|-> o_fiber_tx_bit == ($past(o_fiber_tx_bit) ^ $past(i_tx_code_bit))) else $error("tx nrzi");
	chk_rx_nrzi: assert property (o_fiber_if_en && $past(o_fiber_if_en, 2)
		|-> o_rx_code_bit == ($past(i_fiber_rx_bit) ^ $past(i_fiber_rx_bit, 2))) else $error("rx nrzi");
	chk_tp_off: assert property (o_fiber_if_en |-> !o_tp_xcvr_en) else $error("tp on");
	chk_fiber_byp: assert property (o_fiber_if_en |-> o_scrambler_bypass) else $error("no bypass");
	chk_crs_cause: assert property (o_mii_crs |-> $past(i_rx_carrier)) else $error("crs");
	chk_fault_cnt: assert property ($fell(o_mii_enable) |-> pats == 2'h3) else $error("early fault");
endmodule
bind fiber_mode_far_end_fault fiber_fault_asserts u_chk (.i_core_clk, .i_rst_b, .i_tx_code_bit, .i_tx_idle,
	.i_fiber_signal_detect, .i_fiber_rx_bit, .i_rx_carrier, .o_fiber_tx_bit, .o_rx_code_bit,
	.o_mii_crs, .o_mii_enable, .o_fiber_if_en, .o_tp_xcvr_en, .o_scrambler_bypass);

// ===== optical_xcvr_model.sv
`timescale 1ns/1ns
module optical_xcvr_model
(
	input  wire logic i_core_clk,
	input  wire logic i_signal_on,
	input  wire logic i_far_fault,
	output logic      o_signal_detect,
	output logic      o_rx_line
);
	logic [7:0] run = 8'h0;
	logic       code;
	initial o_rx_line = 1'b0;
	// idle run before the fault makes the first pattern long
	assign code = !(i_far_fault && run >= 8'h54);
	always @(posedge i_core_clk) o_signal_detect <= i_signal_on;
	always @(posedge i_core_clk) o_rx_line <= o_rx_line ^ code;
	always @(posedge i_core_clk) run <= code ? run + {7'h0, run != 8'hFF} : 8'h0;
endmodule

// ===== tb.sv
`timescale 1ns/1ns
`include "fiber_fault_defines.svh"
module tb;
	import fiber_fault_pkg::*;
	typedef struct {reg_addr_t a; reg_data_t e;} row_s;
	logic      i_core_clk = 0, i_rst_b = 0, i_fiber_select_pin_b = 1, i_wr = 0, i_rd = 0, txp;
	logic      i_tx_code_bit = 1, i_tx_idle = 1, i_rx_carrier = 0, sig_on = 1, far_flt = 0;
	logic      i_fiber_signal_detect, i_fiber_rx_bit, o_fiber_tx_bit, o_rx_code_bit, o_mii_crs;
	logic      o_mii_enable, o_fiber_if_en, o_tp_xcvr_en, o_scrambler_bypass, o_sd_bias_en;
	reg_addr_t i_addr = 0;
	reg_data_t i_wdata = 0, o_rdata, rd_v;
	int        n_fail = 0, checks_done = 0, zc;
	row_s      rows[7] = '{'{`ADDR_BASIC_CONTROL, `RST_BASIC_CONTROL}, '{`ADDR_BASIC_STATUS, 16'h0},
		'{`ADDR_PHY_STATUS, 16'h0}, '{`ADDR_PCS_CONFIG, 16'h4000}, '{`ADDR_LOOPBACK_BYP, 16'h0},
		'{`ADDR_PHY_CONTROL, 16'h0}, '{5'h1F, 16'h0}};
	always #5 i_core_clk = ~i_core_clk;
	always @(negedge i_core_clk)
	begin
		zc += int'(o_fiber_tx_bit === txp);
		txp = o_fiber_tx_bit;
	end
	fiber_mode_far_end_fault u_dut (.i_core_clk, .i_rst_b, .i_fiber_select_pin_b, .i_addr, .i_wdata, .i_wr,
		.i_rd, .o_rdata, .i_fiber_signal_detect, .i_tx_code_bit, .i_tx_idle, .o_fiber_tx_bit, .i_fiber_rx_bit,
		.o_rx_code_bit, .i_rx_carrier, .o_mii_crs, .o_mii_enable, .o_fiber_if_en, .o_tp_xcvr_en,
		.o_scrambler_bypass, .o_sd_bias_en);
	optical_xcvr_model u_xcvr (.i_core_clk, .i_signal_on(sig_on), .i_far_fault(far_flt),
		.o_signal_detect(i_fiber_signal_detect), .o_rx_line(i_fiber_rx_bit));
	task ck(input string n, input reg_data_t e, input reg_data_t s);
		checks_done++;
		if (s !== e)
		begin
			$display("[FAIL] %s exp %h got %h", n, e, s);
			n_fail++;
		end
	endtask
	task wr(input reg_addr_t a, input reg_data_t d);
		@(posedge i_core_clk);
		i_wr <= 1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 0;
	endtask
	task rd(input reg_addr_t a);
		@(posedge i_core_clk);
		i_rd <= 1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 0;
		#1 rd_v = o_rdata;
	endtask
	task do_reset(input logic pin);
		i_rst_b <= 0;
		i_fiber_select_pin_b <= pin;
		repeat (6) @(posedge i_core_clk);
		i_rst_b <= 1;
		repeat (2) @(posedge i_core_clk);
		#1;
	endtask
	// idle line over n cycles: any nrzi zero?
	task win(input int n, input reg_data_t e, input string s);
		repeat (12) @(posedge i_core_clk);
		zc = 0;
		repeat (n) @(posedge i_core_clk);
		ck(s, e, reg_data_t'(zc != 0));
	endtask
	task finish_test;
		if (n_fail == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		do_reset(1);
		foreach (rows[i])
		begin
			rd(rows[i].a);
			ck("reg", rows[i].e, rd_v);
		end
		ck("tp", 1, o_tp_xcvr_en);
		do_reset(0);
		ck("fx", 1, o_fiber_if_en);
		ck("byp", 1, o_scrambler_bypass);
		sig_on <= 0;
		win(300, 0, "an_on");
		wr(`ADDR_BASIC_CONTROL, 16'h0);
		win(300, 1, "fault_tx");
		sig_on <= 1;
		win(200, 0, "sd_back");
		i_tx_idle <= 0;
		repeat (16) @(posedge i_core_clk) i_tx_code_bit <= ~i_tx_code_bit;
		i_tx_idle <= 1;
		wr(`ADDR_PCS_CONFIG, 16'h8000);
		sig_on <= 0;
		win(300, 0, "fault_off");
		ck("bias", 1, o_sd_bias_en);
		i_rx_carrier <= 1;
		@(posedge i_core_clk);
		i_rx_carrier <= 0;
		#1 ck("crs_on", 1, o_mii_crs);
		// remote fault only latches with fault signalling enabled; the pattern counter runs regardless
		wr(`ADDR_PCS_CONFIG, 16'hC000);
		far_flt <= 1;
		repeat (450) @(posedge i_core_clk);
		rd(`ADDR_BASIC_STATUS);
		ck("remote", 16'h10, rd_v & 16'h10);
		rd(`ADDR_PHY_STATUS);
		ck("phy_sts", 16'h80, rd_v & 16'h80);
		ck("mii_en", 0, o_mii_enable);
		i_rx_carrier <= 1;
		repeat (2) @(posedge i_core_clk);
		i_rx_carrier <= 0;
		#1 ck("crs", 0, o_mii_crs);
		far_flt <= 0;
		repeat (200) @(posedge i_core_clk);
		ck("mii_back", 1, o_mii_enable);
		rd(`ADDR_BASIC_STATUS);
		ck("held", 16'h10, rd_v & 16'h10);
		rd(`ADDR_BASIC_STATUS);
		ck("cleared", 16'h0, rd_v & 16'h10);
		do_reset(1);
		wr(`ADDR_PHY_CONTROL, 16'h20);
		rd(`ADDR_PHY_CONTROL);
		ck("fx_rd", 16'h20, rd_v);
		ck("fx_bit", 1, o_fiber_if_en);
		wr(`ADDR_PHY_CONTROL, 16'h0);
		wr(`ADDR_LOOPBACK_BYP, 16'h0980);
		wr(`ADDR_BASIC_CONTROL, 16'h0);
		win(300, 1, "sw_fault");
		wr(`ADDR_LOOPBACK_BYP, 16'h0800);
		wr(`ADDR_PCS_CONFIG, 16'h0000);
		rd(`ADDR_LOOPBACK_BYP);
		ck("lb_rd", 16'h0800, rd_v);
		ck("byp_only", 1, o_scrambler_bypass);
		ck("fx_off", 0, o_fiber_if_en);
		finish_test;
	end
endmodule
